// *** core/core_rt_timer_counter.sv ***
// real-time 16-bit timer/counter with prescaler and overflow flag
`timescale 1ns/10ps
module core_rt_timer_counter
  import rt_timer_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [7:0] file_addr_in,
  input wire logic file_wr_in,
  input wire logic [7:0] file_wdata_in,
  input wire logic ext_count_pin_in,
  output logic [7:0] file_rdata_out,
  output logic overflow_irq_out
);
  prescale_if ps ();

  logic [7:0] tick_control_status_q;
  logic [7:0] cpu_status_word_q;
  logic [7:0] interrupt_status_word_q;
  logic [7:0] count_low_q;
  logic [7:0] count_high_q;
  logic [1:0] phase_q;
  logic pin_meta_q;
  logic pin_sync_q;
  logic sample_q;
  logic pend_q;
  logic hold_low_q;
  logic hold_high_q;
  logic tick;
  logic sample_en;
  logic edge_seen;
  logic inc;
  logic timer_mode;
  logic wr_low;
  logic wr_high;
  logic wr_int;
  logic carry_low;
  logic step_low;
  logic step_high;
  logic wrap;
  logic irq_d;

  assign timer_mode = tick_control_status_q[CS_CLOCK_SRC_BIT];
  assign wr_low = file_wr_in && (file_addr_in == ADDR_COUNT_LOW);
  assign wr_high = file_wr_in && (file_addr_in == ADDR_COUNT_HIGH);
  assign wr_int = file_wr_in && (file_addr_in == ADDR_INT_STATUS);

  // instruction clock: one enable pulse every four oscillator cycles
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      phase_q <= 2'd0;
    else
      phase_q <= phase_q + 2'd1;
  end
  assign tick = (phase_q == PHASE_LAST);
  assign sample_en = (phase_q == PHASE_SAMPLE_A) || (phase_q == PHASE_SAMPLE_B);

  // two-flop synchroniser for the count pin
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end
    else
    begin
      pin_meta_q <= ext_count_pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // prescaler hookup; falling edges become rising by inversion
  assign ps.clear = wr_low || wr_high;
  assign ps.timer_mode = timer_mode;
  assign ps.ratio_code = tick_control_status_q[CS_RATIO_MSB:CS_RATIO_LSB];
  assign ps.tick = tick;
  assign ps.src_level = tick_control_status_q[CS_EDGE_BIT] ? pin_sync_q
    : !pin_sync_q;

  rt_prescaler u_prescaler (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .ps(ps.pre)
  );

  // prescaler output sampled twice per instruction cycle; starts high like idle source
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      sample_q <= 1'b1;
    else if (sample_en)
      sample_q <= ps.prescaler_output;
  end
  assign edge_seen = sample_en && ps.prescaler_output && !sample_q;

  // pending external edge, consumed at the next instruction tick
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      pend_q <= 1'b0;
    else if (tick || ps.clear || timer_mode)
      pend_q <= 1'b0;
    else if (edge_seen)
      pend_q <= 1'b1;
  end

  // increment request for this instruction cycle
  always_comb
  begin
    if (timer_mode)
      inc = ps.timer_pulse;
    else
      inc = tick && (pend_q || edge_seen);
  end

  // per-half increment holds after a byte write
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      hold_low_q <= 1'b0;
      hold_high_q <= 1'b0;
    end
    else
    begin
      hold_low_q <= wr_low || (hold_low_q && !tick);
      hold_high_q <= wr_high || (hold_high_q && !tick);
    end
  end

  assign carry_low = (count_low_q == 8'hff);
  assign step_low = inc && !hold_low_q && !wr_low;
  assign step_high = step_low && carry_low && !hold_high_q && !wr_high;
  assign wrap = step_low && step_high && (count_high_q == 8'hff);

  // low count byte
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      count_low_q <= RST_COUNT_BYTE;
    else if (wr_low)
      count_low_q <= file_wdata_in;
    else if (step_low)
      count_low_q <= count_low_q + 8'h01;
  end

  // high count byte
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      count_high_q <= RST_COUNT_BYTE;
    else if (wr_high)
      count_high_q <= file_wdata_in;
    else if (step_high)
      count_high_q <= count_high_q + 8'h01;
  end

  // control/status and cpu status registers
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      tick_control_status_q <= RST_CONTROL_STATUS;
      cpu_status_word_q <= RST_CPU_STATUS;
    end
    else if (file_wr_in && (file_addr_in == ADDR_CONTROL_STATUS))
      tick_control_status_q <= file_wdata_in & CS_USED_MASK;
    else if (file_wr_in && (file_addr_in == ADDR_CPU_STATUS))
      cpu_status_word_q <= file_wdata_in;
  end

  // interrupt status; a wrap wins over a software clear
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      interrupt_status_word_q <= RST_INT_STATUS;
    else
    begin
      if (wr_int)
        interrupt_status_word_q <= file_wdata_in;
      if (wrap)
        interrupt_status_word_q[INT_FLAG_BIT] <= 1'b1;
    end
  end

  // overflow interrupt request, gated by mask and global disable
  assign irq_d = interrupt_status_word_q[INT_FLAG_BIT]
    && interrupt_status_word_q[INT_MASK_BIT]
    && !cpu_status_word_q[CPU_GLOBAL_DISABLE_BIT];
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      overflow_irq_out <= 1'b0;
    else
      overflow_irq_out <= irq_d;
  end

  // registered read data; unmapped addresses read zero
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      file_rdata_out <= 8'h00;
    else if (file_addr_in == ADDR_CONTROL_STATUS)
      file_rdata_out <= tick_control_status_q;
    else if (file_addr_in == ADDR_CPU_STATUS)
      file_rdata_out <= cpu_status_word_q;
    else if (file_addr_in == ADDR_INT_STATUS)
      file_rdata_out <= interrupt_status_word_q;
    else if (file_addr_in == ADDR_COUNT_LOW)
      file_rdata_out <= count_low_q;
    else if (file_addr_in == ADDR_COUNT_HIGH)
      file_rdata_out <= count_high_q;
    else
      file_rdata_out <= 8'h00;
  end

  property p_wrap_sets_flag;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    wrap |=> interrupt_status_word_q[INT_FLAG_BIT] && count_low_q == 8'h00
      && count_high_q == 8'h00;
  endproperty
  a_wrap_sets_flag: assert property (p_wrap_sets_flag)
    else $error("wrap did not zero count and set flag");

  property p_flag_sticky;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    interrupt_status_word_q[INT_FLAG_BIT] && !wr_int
      |=> interrupt_status_word_q[INT_FLAG_BIT];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("overflow flag cleared without software write");

  property p_mask_blocks;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    !interrupt_status_word_q[INT_MASK_BIT] |=> !overflow_irq_out;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks)
    else $error("interrupt raised while masked");

  property p_tick_period;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    tick |=> !tick [*3] ##1 tick;
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("instruction tick not every fourth cycle");

  property p_timer_one_to_one;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    timer_mode && ps.ratio_code == 4'd0 && tick && !hold_low_q && !wr_low
      |=> count_low_q == 8'($past(count_low_q) + 8'h01);
  endproperty
  a_timer_one_to_one: assert property (p_timer_one_to_one)
    else $error("timer 1:1 did not count each instruction cycle");

  property p_hold_low;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    wr_low ##1 !wr_low |=> count_low_q == $past(count_low_q);
  endproperty
  a_hold_low: assert property (p_hold_low)
    else $error("low byte changed right after its write");

  property p_hold_high_blocks;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    hold_high_q && tick && !wr_high |=> count_high_q == $past(count_high_q);
  endproperty
  a_hold_high_blocks: assert property (p_hold_high_blocks)
    else $error("high byte stepped in cycle after its write");

  property p_quiet_between_ticks;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    !tick && !wr_low |=> count_low_q == $past(count_low_q);
  endproperty
  a_quiet_between_ticks: assert property (p_quiet_between_ticks)
    else $error("count moved outside an instruction tick");

  property p_edge_counted;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    !timer_mode && edge_seen && !ps.clear && !hold_low_q
      ##1 (!ps.clear && !timer_mode) [*2]
      |=> count_low_q != $past(count_low_q, 3);
  endproperty
  a_edge_counted: assert property (p_edge_counted)
    else $error("sampled external edge not counted in time");

  property p_low_write_loads;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    wr_low |=> count_low_q == $past(file_wdata_in);
  endproperty
  a_low_write_loads: assert property (p_low_write_loads)
    else $error("low count byte did not take written value");

  property p_high_write_loads;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    wr_high |=> count_high_q == $past(file_wdata_in);
  endproperty
  a_high_write_loads: assert property (p_high_write_loads)
    else $error("high count byte did not take written value");

  property p_carry_into_high;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    step_low && carry_low && !hold_high_q && !wr_high
      |=> count_high_q == 8'($past(count_high_q) + 8'h01);
  endproperty
  a_carry_into_high: assert property (p_carry_into_high)
    else $error("high byte missed carry from low byte");

  property p_other_half_counts;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    hold_high_q && tick && inc && !hold_low_q && !wr_low
      |=> count_low_q == 8'($past(count_low_q) + 8'h01);
  endproperty
  a_other_half_counts: assert property (p_other_half_counts)
    else $error("low byte blocked by high byte write hold");

  property p_global_disable_blocks;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    cpu_status_word_q[CPU_GLOBAL_DISABLE_BIT] |=> !overflow_irq_out;
  endproperty
  a_global_disable_blocks: assert property (p_global_disable_blocks)
    else $error("interrupt raised while globally disabled");

  property p_pend_consumed;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    tick |=> !pend_q;
  endproperty
  a_pend_consumed: assert property (p_pend_consumed)
    else $error("pending edge survived an instruction tick");
endmodule

// *** core/prescale_if.sv ***
// signals between the timer control logic and its prescaler
`timescale 1ns/10ps
interface prescale_if;
  import rt_timer_pkg::*;
  logic clear;
  logic timer_mode;
  logic [3:0] ratio_code;
  logic tick;
  logic src_level;
  logic timer_pulse;
  logic prescaler_output;

  modport ctrl (output clear, timer_mode, ratio_code, tick, src_level,
    input timer_pulse, prescaler_output);
  modport pre (input clear, timer_mode, ratio_code, tick, src_level,
    output timer_pulse, prescaler_output);
endinterface

// *** core/rt_prescaler.sv ***
// 8-bit prescaler: divides instruction ticks or external edges
`timescale 1ns/10ps
module rt_prescaler
  import rt_timer_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  prescale_if.pre ps
);
  logic [7:0] cnt_q;
  logic src_prev_q;
  logic src_rise;
  logic [7:0] mask;

  assign mask = ratio_mask(ps.ratio_code);
  assign src_rise = ps.src_level && !src_prev_q;

  // previous level of the selected source; resets high like the idle source
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      src_prev_q <= 1'b1; // no false edge straight after reset
    else
      src_prev_q <= ps.src_level;
  end

  // divider state, cleared by any count byte write
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      cnt_q <= RST_PRESCALE;
    else if (ps.clear)
      cnt_q <= RST_PRESCALE;
    else if (ps.timer_mode ? ps.tick : src_rise)
      cnt_q <= cnt_q + 8'h01;
  end

  // timer mode: pass one tick in every 2^code, codes above 8 as one in 256
  assign ps.timer_pulse = ps.tick && ((cnt_q & mask) == mask);

  // counter mode: symmetrical divided level, or the selected source level itself at 1:1
  always_comb
  begin
    if (ps.ratio_code == 4'd0)
      ps.prescaler_output = ps.src_level;
    else if (ps.ratio_code > RATIO_CODE_MAX)
      ps.prescaler_output = cnt_q[7];
    else
      ps.prescaler_output = cnt_q[3'(ps.ratio_code - 4'd1)];
  end

  property p_clear_zero;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    ps.clear |=> cnt_q == 8'h00;
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("prescaler not cleared after count write");
endmodule

// *** core/rt_timer_pkg.sv ***
// constants, register map and helpers for the real-time timer/counter
package rt_timer_pkg;
  // file register addresses
  localparam logic [7:0] ADDR_CONTROL_STATUS = 8'h05;
  localparam logic [7:0] ADDR_CPU_STATUS = 8'h06;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h07;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h0b;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h0c;

  // reset values
  localparam logic [7:0] RST_CONTROL_STATUS = 8'h00;
  localparam logic [7:0] RST_CPU_STATUS = 8'h30;
  localparam logic [7:0] RST_INT_STATUS = 8'h00;
  localparam logic [7:0] RST_COUNT_BYTE = 8'h00;
  localparam logic [7:0] RST_PRESCALE = 8'h00;

  // control/status field positions
  localparam int CS_RATIO_LSB = 0;
  localparam int CS_RATIO_MSB = 3;
  localparam int CS_CLOCK_SRC_BIT = 5;
  localparam int CS_EDGE_BIT = 6;
  localparam logic [7:0] CS_USED_MASK = 8'h6f;

  // interrupt status and cpu status fields
  localparam int INT_MASK_BIT = 1;
  localparam int INT_FLAG_BIT = 5;
  localparam int CPU_GLOBAL_DISABLE_BIT = 4;

  // instruction cycle: oscillator divided by four
  localparam logic [1:0] PHASE_LAST = 2'd3;
  localparam logic [1:0] PHASE_SAMPLE_A = 2'd1;
  localparam logic [1:0] PHASE_SAMPLE_B = 2'd3;
  localparam logic [3:0] RATIO_CODE_MAX = 4'd8;

  // low bits of the prescaler that must all be ones to pass a source pulse
  function automatic logic [7:0] ratio_mask(input logic [3:0] code);
    logic [8:0] m;
    m = 9'h000;
    if (code > RATIO_CODE_MAX)
    begin
      m = 9'h0ff;
    end
    else
    begin
      m = 9'((9'h001 << code) - 9'h001);
    end
    return m[7:0];
  endfunction
endpackage

// *** testbench/core_rt_timer_counter_bench.sv ***
// self-checking bench for the real-time timer/counter
`timescale 1ns/10ps
module core_rt_timer_counter_bench
  import rt_timer_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] file_addr_in = 8'h00;
  logic file_wr_in = 1'b0;
  logic [7:0] file_wdata_in = 8'h00;
  logic ext_count_pin_in;
  logic [7:0] file_rdata_out;
  logic overflow_irq_out;
  logic go = 1'b0;
  logic busy;
  logic lvl = 1'b0;
  logic [7:0] a;
  logic [7:0] b;
  logic [31:0] rng = 32'h64225593;
  int failures = 0;
  int n_compared = 0;
  int cycle_count = 0;
  int e;
  int hold_code[6] = '{0, 0, 2, 2, 3, 3};
  int hold_gap[6] = '{4, 20, 12, 16, 28, 32};
  int hold_add[6] = '{0, 4, 0, 1, 0, 1};

  core_rt_timer_counter core_rt_timer_counter_inst (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .file_addr_in(file_addr_in),
    .file_wr_in(file_wr_in),
    .file_wdata_in(file_wdata_in),
    .ext_count_pin_in(ext_count_pin_in),
    .file_rdata_out(file_rdata_out),
    .overflow_irq_out(overflow_irq_out)
  );
  ext_count_source ext_count_source_inst (
    .go_in(go),
    .toggles_in(8'd21),
    .half_in(8'd3),
    .pin_out(ext_count_pin_in),
    .busy_out(busy)
  );

  // 20 mhz clock
  always #25 clk_sys_in = ~clk_sys_in;

  // hang guard
  always @(posedge clk_sys_in)
  begin
    cycle_count++;
    if (cycle_count == 20000)
    begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      summarize();
    end
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // active edges in a burst of n toggles from a start level
  function automatic int active_edges(input logic start, input logic rising, input int n);
    return (start ^ rising) ? (n + 1) / 2 : n / 2;
  endfunction
  // count steps after a cleared prescaler at a ratio code
  function automatic int counted(input int edges, input int code);
    return code == 0 ? edges : (edges + (1 << (code - 1))) >> code;
  endfunction

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_sys_in);
    file_addr_in = addr;
    file_wdata_in = data;
    file_wr_in = 1'b1;
    @(negedge clk_sys_in);
    file_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    file_addr_in = addr;
    @(negedge clk_sys_in);
    data = file_rdata_out;
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t irq %b expected %b", $time, got, exp);
    end
  endtask
  task automatic expect_rd(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    rd(addr, got);
    check_byte(got, exp);
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (6) @(negedge clk_sys_in);
    check_byte(file_rdata_out, 8'h00);
    check_bit(overflow_irq_out, 1'b0);
    rst_b_in = 1'b1;
    expect_rd(ADDR_COUNT_LOW, RST_COUNT_BYTE);
    expect_rd(ADDR_COUNT_HIGH, RST_COUNT_BYTE);
    expect_rd(ADDR_CONTROL_STATUS, RST_CONTROL_STATUS);
    expect_rd(ADDR_CPU_STATUS, RST_CPU_STATUS);
    expect_rd(ADDR_INT_STATUS, RST_INT_STATUS);
    $display("test reset values done");
    for (int i = 0; i < 8; i++)
    begin
      rng = xorshift(rng);
      wr(ADDR_CONTROL_STATUS, rng[7:0]);
      expect_rd(ADDR_CONTROL_STATUS, rng[7:0] & CS_USED_MASK);
      wr(8'h10 | rng[15:8], rng[23:16]);
      expect_rd(8'h10 | rng[15:8], 8'h00);
    end
    wr(ADDR_CONTROL_STATUS, 8'h00);
    repeat (16) @(negedge clk_sys_in);
    for (int i = 0; i < 8; i++)
    begin
      rng = xorshift(rng);
      wr(ADDR_COUNT_LOW, rng[7:0]);
      wr(ADDR_COUNT_HIGH, rng[15:8]);
      expect_rd(ADDR_COUNT_LOW, rng[7:0]);
      expect_rd(ADDR_COUNT_HIGH, rng[15:8]);
    end
    $display("test register access done");
    // held step and cleared prescaler after a low byte write
    for (int i = 0; i < 6; i++)
    begin
      wr(ADDR_CONTROL_STATUS, 8'h20 | 8'(hold_code[i]));
      wr(ADDR_COUNT_LOW, 8'h10);
      repeat (hold_gap[i]) @(negedge clk_sys_in);
      expect_rd(ADDR_COUNT_LOW, 8'h10 + 8'(hold_add[i]));
    end
    $display("test write hold done");
    // timer mode: three steps per window at every ratio
    for (int c = 0; c <= 8; c++)
    begin
      wr(ADDR_CONTROL_STATUS, 8'h20 | 8'(c));
      repeat (8) @(negedge clk_sys_in);
      rd(ADDR_COUNT_LOW, a);
      repeat ((12 << c) - 1) @(negedge clk_sys_in);
      rd(ADDR_COUNT_LOW, b);
      check_byte(b - a, 8'h03);
    end
    $display("test timer ratios done");
    // counter mode: bursts on the pin with each edge and small ratios
    for (int i = 0; i < 8; i++)
    begin
      e = active_edges(lvl, 1'(i % 2), 21);
      wr(ADDR_CONTROL_STATUS, 8'((i % 2) * 64 + i / 2));
      repeat (16) @(negedge clk_sys_in);
      wr(ADDR_COUNT_LOW, 8'h00);
      repeat (8) @(negedge clk_sys_in);
      go = 1'b1;
      @(negedge clk_sys_in);
      go = 1'b0;
      for (int k = 0; k < 200 && busy; k++) @(negedge clk_sys_in);
      repeat (16) @(negedge clk_sys_in);
      expect_rd(ADDR_COUNT_LOW, 8'(counted(e, i / 2)));
      lvl = ~lvl;
    end
    $display("test counter mode done");
    // wrap, flag, mask and global disable
    wr(ADDR_CONTROL_STATUS, 8'h20);
    wr(ADDR_INT_STATUS, 8'h02);
    wr(ADDR_CPU_STATUS, 8'h20);
    wr(ADDR_COUNT_LOW, 8'hfe);
    wr(ADDR_COUNT_HIGH, 8'hff);
    expect_rd(ADDR_INT_STATUS, 8'h02);
    repeat (24) @(negedge clk_sys_in);
    expect_rd(ADDR_INT_STATUS, 8'h22);
    check_bit(overflow_irq_out, 1'b1);
    expect_rd(ADDR_COUNT_HIGH, 8'h00);
    repeat (40) @(negedge clk_sys_in);
    expect_rd(ADDR_INT_STATUS, 8'h22);
    wr(ADDR_INT_STATUS, 8'h20);
    @(negedge clk_sys_in);
    check_bit(overflow_irq_out, 1'b0);
    wr(ADDR_INT_STATUS, 8'h22);
    wr(ADDR_CPU_STATUS, 8'h30);
    @(negedge clk_sys_in);
    check_bit(overflow_irq_out, 1'b0);
    wr(ADDR_CPU_STATUS, 8'h20);
    @(negedge clk_sys_in);
    check_bit(overflow_irq_out, 1'b1);
    wr(ADDR_INT_STATUS, 8'h02);
    @(negedge clk_sys_in);
    check_bit(overflow_irq_out, 1'b0);
    expect_rd(ADDR_INT_STATUS, 8'h02);
    $display("test overflow done");
    summarize();
  end
endmodule

// *** testbench/ext_count_source.sv ***
// external count source: a burst of pin toggles on request
`timescale 1ns/10ps
module ext_count_source (
  input wire logic go_in,
  input wire logic [7:0] toggles_in,
  input wire logic [7:0] half_in,
  output logic pin_out,
  output logic busy_out
);
  // pin starts low and stands still between bursts
  initial
  begin
    pin_out = 1'b0;
    busy_out = 1'b0;
  end
  // burst with level times in whole clock periods, offset from the clock
  always @(posedge go_in)
  begin
    busy_out = 1'b1;
    #13;
    repeat (toggles_in)
    begin
      #(half_in * 50) pin_out = ~pin_out;
    end
    #(half_in * 50) busy_out = 1'b0;
  end
endmodule
